// file: logic/fsd_pkg.sv
// Constants, encodings and timing figures for the floppy serdes decoder
`default_nettype none

package fsd_pkg;

    // Command addresses within the decoded page
    localparam logic [15:0] REG_SYNC_DATA_READ = 16'h4000;
    localparam logic [15:0] REG_SYNC_CLOCK_READ = 16'h4001;
    localparam logic [15:0] REG_DATA_BYTE_READ = 16'h4002;
    localparam logic [15:0] REG_CLOCK_BYTE_READ = 16'h4003;
    localparam logic [15:0] REG_DRIVE_STATUS = 16'h4004;
    localparam logic [15:0] REG_DRIVE_CONTROL_LOW = 16'h4005;
    localparam logic [15:0] REG_DRIVE_CONTROL_HIGH = 16'h4006;
    localparam logic [15:0] REG_WRITE_DATA_LOAD = 16'h4007;

    // Command index taken from the low address bits
    localparam logic [2:0] CMD_SYNC_DATA = REG_SYNC_DATA_READ[2:0];
    localparam logic [2:0] CMD_SYNC_CLOCK = REG_SYNC_CLOCK_READ[2:0];
    localparam logic [2:0] CMD_DATA_BYTE = REG_DATA_BYTE_READ[2:0];
    localparam logic [2:0] CMD_CLOCK_BYTE = REG_CLOCK_BYTE_READ[2:0];
    localparam logic [2:0] CMD_STATUS = REG_DRIVE_STATUS[2:0];
    localparam logic [2:0] CMD_CTL_LOW = REG_DRIVE_CONTROL_LOW[2:0];
    localparam logic [2:0] CMD_CTL_HIGH = REG_DRIVE_CONTROL_HIGH[2:0];
    localparam logic [2:0] CMD_LOAD_DATA = REG_WRITE_DATA_LOAD[2:0];

    // Address bit positions
    localparam int ADDR_BIT_FIFTEEN = 15;
    localparam int ADDR_BIT_FOURTEEN = 14;
    localparam int ADDR_BIT_THREE = 3;
    localparam int ADDR_BIT_FOUR = 4;

    // Missing clock patterns, indexed by address bits four and three; fill and unmapped read bytes
    localparam logic [7:0] CLK_PAT_0 = 8'hFF;
    localparam logic [7:0] CLK_PAT_1 = 8'hEF;
    localparam logic [7:0] CLK_PAT_2 = 8'hD6;
    localparam logic [7:0] CLK_PAT_3 = 8'hC7;
    localparam logic [7:0] FILL_DATA = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Sync mark position and byte length
    localparam int SYNC_BIT = 5;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = BYTE_BITS - 4'h1;

    // Control field positions and reset values
    localparam int CTL_BUS_BIT_SEVEN = 7;
    localparam int CTL_HI_STEP = 0;
    localparam int CTL_HI_DIR = 1;
    localparam int CTL_HI_WRITE_EN = 2;
    localparam int CTL_HI_OSC_SYNC = 3;
    localparam int CTL_HI_IRQ = 6;
    localparam int CTL_HI_HOST_A15 = 7;
    localparam int CTL_LO_HEAD_LOAD = 4;
    localparam int CTL_LO_BEYOND_43 = 5;
    localparam logic [7:0] CTL_LOW_RESET = 8'h00;
    localparam logic [7:0] CTL_HIGH_RESET = 8'h00;

    // Timing figures
    localparam int SYS_CLK_NS = 40;
    localparam int FAST_BIT_LIMIT_NS = 2500;
    localparam int FAST_BIT_LIMIT_CYC = FAST_BIT_LIMIT_NS / SYS_CLK_NS;

    // Receive buffer shape
    localparam int RX_FIFO_DEPTH = 4;
    localparam int RX_FIFO_WIDTH = 8;

endpackage

`default_nettype wire

// file: logic/fsd_top.sv
// Floppy serdes command decoder with its receive FIFO
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module fsd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Filling side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Draining side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = in_valid_in & in_ready_out;
    wire pop = out_valid_out & out_ready_in;
    wire [AW-1:0] wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 :
                                wr_ptr_reg + AW'(1);
    wire [AW-1:0] rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 :
                                rd_ptr_reg + AW'(1);

    assign in_ready_out = (count_reg != FULL_COUNT);
    assign out_valid_out = (count_reg != '0);
    assign out_data_out = mem[rd_ptr_reg];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_next;
            if (pop) rd_ptr_reg <= rd_ptr_next;
            if (push && !pop) count_reg <= count_reg + (AW+1)'(1);
            else if (pop && !push) count_reg <= count_reg - (AW+1)'(1);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module fsd_top
    import fsd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Processor memory bus
    input wire logic [15:0] addr_in,
    input wire logic [7:0] data_in,
    input wire logic rd_in,
    input wire logic wr_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    output logic ready_out,
    // Drive inputs
    input wire logic shift_clk_in,
    input wire logic read_clk_in,
    input wire logic read_data_in,
    input wire logic sector_in,
    input wire logic index_in,
    input wire logic [4:0] drive_lines_in,
    // Drive outputs
    output logic [3:0] drive_select_out,
    output logic head_load_out,
    output logic beyond_track_out,
    output logic step_out,
    output logic step_dir_out,
    output logic write_enable_out,
    output logic phase_locked_osc_out,
    output logic write_clk_bit_out,
    output logic write_data_bit_out,
    // Host side control bits
    output logic host_addr_bit_fifteen_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];
    logic [9:0] pin_s1_reg;
    logic [9:0] pin_s2_reg;
    logic shift_clk_old_reg;
    logic index_old_reg;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) rst_sync_reg <= 2'h0;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 10'h000;
            pin_s2_reg <= 10'h000;
            shift_clk_old_reg <= 1'b0;
            index_old_reg <= 1'b0;
        end else begin
            pin_s1_reg <= {shift_clk_in, read_clk_in, read_data_in,
                           sector_in, index_in, drive_lines_in};
            pin_s2_reg <= pin_s1_reg;
            shift_clk_old_reg <= pin_s2_reg[9];
            index_old_reg <= pin_s2_reg[5];
        end
    end

    wire shift_edge = pin_s2_reg[9] & ~shift_clk_old_reg;
    wire serial_clk = ~pin_s2_reg[8];
    wire serial_data = ~pin_s2_reg[7];
    wire sector_s = pin_s2_reg[6];
    wire index_rise = pin_s2_reg[5] & ~index_old_reg;
    wire [4:0] lines_s = pin_s2_reg[4:0];

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    logic done_reg;
    logic sync_wait_reg;
    logic halt_clk_reg;
    logic clk_fresh_reg;
    logic pend_valid_reg;
    logic [7:0] ctl_low_reg;
    logic [7:0] ctl_high_reg;
    logic [7:0] clk_sr_reg;
    logic [7:0] data_sr_reg;
    logic [7:0] clk_snap_reg;
    logic fifo_valid;
    logic fifo_in_ready;
    logic [7:0] fifo_data;

    wire page_sel = ~addr_in[ADDR_BIT_FIFTEEN]
                  & addr_in[ADDR_BIT_FOURTEEN];
    wire cs = page_sel & (rd_in | wr_in);
    wire [2:0] cmd = addr_in[2:0];
    wire cs_rd = cs & rd_in & ~done_reg;
    wire cs_wr = cs & wr_in & ~rd_in & ~done_reg;
    wire [1:0] pat_sel = {addr_in[ADDR_BIT_FOUR],
                          addr_in[ADDR_BIT_THREE]};
    wire [7:0] pattern = (pat_sel == 2'h0) ? CLK_PAT_0 :
                         (pat_sel == 2'h1) ? CLK_PAT_1 :
                         (pat_sel == 2'h2) ? CLK_PAT_2 : CLK_PAT_3;
    wire sync_hit = sync_wait_reg & clk_sr_reg[SYNC_BIT];

    wire rd_sync = cs_rd & (cmd == CMD_SYNC_DATA);
    wire rd_sclk = cs_rd & (cmd == CMD_SYNC_CLOCK);
    wire rd_data = cs_rd & (cmd == CMD_DATA_BYTE);
    wire rd_clk = cs_rd & (cmd == CMD_CLOCK_BYTE);
    wire wr_low = cs_wr & (cmd == CMD_CTL_LOW);
    wire wr_high = cs_wr & (cmd == CMD_CTL_HIGH);
    wire wr_load = cs_wr & (cmd == CMD_LOAD_DATA);
    wire wr_pat = cs_wr & (cmd == CMD_SYNC_CLOCK);
    wire wr_other = cs_wr & ~wr_low & ~wr_high & ~wr_load & ~wr_pat;

    // Access completes once its wait condition is met
    wire fire_sync = rd_sync & sync_hit;
    wire fire_data = rd_data & fifo_valid;
    wire fire_clk = rd_clk & clk_fresh_reg;
    wire fire_rd = fire_sync | fire_data | fire_clk
                 | (cs_rd & ~rd_sync & ~rd_data & ~rd_clk);
    wire fire_load = (wr_load | wr_pat) & ~pend_valid_reg;
    wire fire_wr = fire_load | wr_low | wr_high | wr_other;
    wire fire = fire_rd | fire_wr;

    // Processor waits while an access is open and not yet finished
    assign ready_out = ~(cs & ~done_reg);
    assign data_oe_out = page_sel & rd_in & done_reg;

    wire [7:0] status_byte;
    wire [7:0] read_mux = (cmd == CMD_SYNC_DATA) ? ~data_sr_reg :
                          (cmd == CMD_SYNC_CLOCK) ? ~clk_sr_reg :
                          (cmd == CMD_DATA_BYTE) ? fifo_data :
                          (cmd == CMD_CLOCK_BYTE) ? clk_snap_reg :
                          (cmd == CMD_STATUS) ? status_byte :
                          UNMAPPED_READ;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
            data_out <= 8'h00;
        end else begin
            done_reg <= cs & (done_reg | fire);
            if (fire_rd) data_out <= read_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive control halves
    logic index_flag_reg;
    logic overrun_reg;
    logic init_byte_reg;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctl_low_reg <= CTL_LOW_RESET;
            ctl_high_reg <= CTL_HIGH_RESET;
        end else begin
            if (wr_low) ctl_low_reg <= data_in;
            if (wr_high) ctl_high_reg <= data_in;
        end
    end

    assign drive_select_out = ctl_low_reg[3:0];
    assign head_load_out = ctl_low_reg[CTL_LO_HEAD_LOAD];
    assign beyond_track_out = ctl_low_reg[CTL_LO_BEYOND_43];
    assign step_out = ctl_high_reg[CTL_HI_STEP];
    assign step_dir_out = ctl_high_reg[CTL_HI_DIR];
    assign write_enable_out = ctl_high_reg[CTL_HI_WRITE_EN];
    assign phase_locked_osc_out = ctl_high_reg[CTL_HI_OSC_SYNC];
    assign host_addr_bit_fifteen_out = ctl_high_reg[CTL_HI_HOST_A15];
    assign irq_out = ctl_high_reg[CTL_HI_IRQ];

    wire write_en = ctl_high_reg[CTL_HI_WRITE_EN];
    assign status_byte = {overrun_reg, index_flag_reg, sector_s, lines_s};

    ////////////////////////////////////////////////////////////////////////
    // Bit counter and shift registers
    logic [3:0] bit_cnt_reg;
    logic [7:0] pend_data_reg;
    logic [7:0] pend_clk_reg;
    logic rx_push_reg;

    // Load enable sits on the last count, so the eighth edge reloads
    wire load_point = shift_edge & (bit_cnt_reg == LAST_BIT) & write_en;
    wire byte_rx = shift_edge & (bit_cnt_reg == LAST_BIT)
                 & ~write_en & ~sync_wait_reg;

    wire clk_mode_a = ~halt_clk_reg;
    wire clk_mode_b = load_point;
    wire data_mode_b = load_point;
    wire [7:0] clk_load = init_byte_reg ? CLK_PAT_0 :
                          pend_valid_reg ? pend_clk_reg : CLK_PAT_0;
    wire [7:0] data_load = init_byte_reg ? FILL_DATA :
                           pend_valid_reg ? pend_data_reg : FILL_DATA;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 4'h0;
        end else if (sync_wait_reg) begin
            bit_cnt_reg <= 4'h0;
        end else if (shift_edge) begin
            bit_cnt_reg <= (bit_cnt_reg == LAST_BIT) ? 4'h0 :
                           bit_cnt_reg + 4'h1;
        end
    end

    // Shifting left moves stage 0 toward stage 7, the serial output
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            clk_sr_reg <= 8'h00;
            data_sr_reg <= 8'h00;
        end else if (shift_edge) begin
            if (clk_mode_a && clk_mode_b) begin
                clk_sr_reg <= clk_load;
            end else if (clk_mode_a) begin
                clk_sr_reg <= {clk_sr_reg[6:0], serial_clk};
            end
            if (data_mode_b) begin
                data_sr_reg <= data_load;
            end else begin
                data_sr_reg <= {data_sr_reg[6:0], serial_data};
            end
        end
    end

    assign write_clk_bit_out = clk_sr_reg[7] & write_en;
    assign write_data_bit_out = data_sr_reg[7] & write_en;

    ////////////////////////////////////////////////////////////////////////
    // Sequencing flags
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sync_wait_reg <= 1'b0;
            halt_clk_reg <= 1'b0;
        end else begin
            if (rd_sync && !sync_wait_reg) begin
                sync_wait_reg <= 1'b1;
                halt_clk_reg <= 1'b0;
            end else if (sync_hit) begin
                sync_wait_reg <= 1'b0;
                halt_clk_reg <= 1'b1;
            end else if (fire_rd && (rd_sclk || rd_clk)) begin
                halt_clk_reg <= 1'b0;
            end
        end
    end

    // A byte slot that empties at the load point can refill no sooner than the next cycle
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pend_valid_reg <= 1'b0;
            pend_data_reg <= 8'h00;
            pend_clk_reg <= 8'h00;
            init_byte_reg <= 1'b0;
        end else begin
            if (fire_load) begin
                pend_valid_reg <= 1'b1;
                pend_clk_reg <= pattern;
                pend_data_reg <= wr_load ? data_in : FILL_DATA;
            end else if (load_point && !init_byte_reg) begin
                pend_valid_reg <= 1'b0;
            end
            if (wr_high) init_byte_reg <= 1'b1;
            else if (load_point) init_byte_reg <= 1'b0;
        end
    end

    // Hardware events win over a clear in the same cycle
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            index_flag_reg <= 1'b0;
            overrun_reg <= 1'b0;
            clk_fresh_reg <= 1'b0;
            rx_push_reg <= 1'b0;
            clk_snap_reg <= 8'h00;
        end else begin
            rx_push_reg <= byte_rx;
            if (index_rise) index_flag_reg <= 1'b1;
            else if (wr_high && data_in[CTL_BUS_BIT_SEVEN])
                index_flag_reg <= 1'b0;
            if (rx_push_reg && !fifo_in_ready) overrun_reg <= 1'b1;
            else if (fire_rd && cmd == CMD_STATUS) overrun_reg <= 1'b0;
            if (rx_push_reg) begin
                clk_fresh_reg <= 1'b1;
                clk_snap_reg <= ~clk_sr_reg;
            end else if (fire_clk) begin
                clk_fresh_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Received bytes wait here until the processor reads them
    fsd_fifo #(
        .WIDTH(RX_FIFO_WIDTH),
        .DEPTH(RX_FIFO_DEPTH)
    ) rx_fifo (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .in_valid_in(rx_push_reg),
        .in_ready_out(fifo_in_ready),
        .in_data_in(~data_sr_reg),
        .out_valid_out(fifo_valid),
        .out_ready_in(fire_data),
        .out_data_out(fifo_data)
    );

endmodule

`default_nettype wire

// file: bench/fsd_assertions.sv
// Port-level concurrent checks for the floppy serdes decoder
`default_nettype none

module fsd_assertions
    import fsd_pkg::*;
(
    // Clock, reset and processor bus
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] data_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic data_oe_out,
    input wire logic ready_out,
    // Drive and host outputs
    input wire logic [3:0] drive_select_out,
    input wire logic head_load_out,
    input wire logic beyond_track_out,
    input wire logic step_out,
    input wire logic step_dir_out,
    input wire logic write_enable_out,
    input wire logic phase_locked_osc_out,
    input wire logic write_clk_bit_out,
    input wire logic write_data_bit_out,
    input wire logic host_addr_bit_fifteen_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire page = addr_in[15:14] == 2'b01;
    wire [2:0] cmd = addr_in[2:0];
    wire [5:0] ctl_lo = {beyond_track_out, head_load_out, drive_select_out};
    wire [5:0] ctl_hi = {host_addr_bit_fifteen_out, irq_out,
        phase_locked_osc_out, write_enable_out, step_dir_out, step_out};
    ////////////////////////////////////////////////////////////////////////
    a_ready_holds_off: assert property (
        $rose(rd_in || wr_in) && page |-> !ready_out)
        else $error("ready high as an access opened");
    a_outside_page: assert property (
        !page |-> ready_out && !data_oe_out)
        else $error("access outside the page decoded");
    a_status_quick: assert property (
        $rose(rd_in) && page && cmd == 3'h4 |=> ready_out && data_oe_out)
        else $error("status read slow");
    a_ctl_low_load: assert property (
        $rose(wr_in) && page && cmd == 3'h5 |=> ctl_lo == data_in[5:0])
        else $error("low control half not loaded");
    a_ctl_high_load: assert property (
        $rose(wr_in) && page && cmd == 3'h6
        |=> ctl_hi == {data_in[7:6], data_in[3:0]})
        else $error("high control half not loaded");
    a_oe_on_read: assert property (
        data_oe_out |-> rd_in && page)
        else $error("bus driven without a read");
    a_read_drives: assert property (
        rd_in && page && cmd <= 3'h4 && ready_out |-> data_oe_out)
        else $error("read released without driving");
    a_write_gated: assert property (
        !write_enable_out |-> !write_clk_bit_out && !write_data_bit_out)
        else $error("write bits without write enable");
    a_reset_clear: assert property (
        $rose(rst_n_in) |-> ctl_lo == 6'h00 && ctl_hi == 6'h00)
        else $error("controls set after reset");
endmodule

bind fsd_top fsd_assertions u_fsd_assertions (
    .sys_clk_in, .rst_n_in, .addr_in, .data_in, .rd_in, .wr_in,
    .data_oe_out, .ready_out, .drive_select_out, .head_load_out,
    .beyond_track_out, .step_out, .step_dir_out, .write_enable_out,
    .phase_locked_osc_out, .write_clk_bit_out, .write_data_bit_out,
    .host_addr_bit_fifteen_out, .irq_out
);

`default_nettype wire

// file: bench/fsd_drv.sv
// Behavioural floppy drive: serial read streams and write capture
`default_nettype none

module fsd_drv (
    // Serial lines towards the decoder
    output logic shift_clk_out,
    output logic read_clk_out,
    output logic read_data_out,
    // Serial write bits from the decoder
    input wire logic wclk_in,
    input wire logic wdat_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cq[$], dq[$], c, d;
    logic wc[$], wd[$];
    logic idle = 1'b1;

    task automatic send(input logic [7:0] ck, input logic [7:0] dt);
        cq.push_back(ck);
        dq.push_back(dt);
    endtask

    // Shift clock stands still while no frame is queued; MSB goes out first
    initial begin
        shift_clk_out = 1'b0;
        read_clk_out = 1'b0;
        read_data_out = 1'b1;
        forever begin
            while (cq.size() == 0) #40;
            idle = 1'b0;
            c = cq.pop_front();
            d = dq.pop_front();
            for (int i = 7; i >= 0; i--) begin
                read_clk_out = c[i];
                read_data_out = d[i];
                #160;
                wc.push_back(wclk_in);
                wd.push_back(wdat_in);
                shift_clk_out = 1'b1;
                #160;
                shift_clk_out = 1'b0;
            end
            if (cq.size() == 0) begin
                // Released lines must not look like a held last bit
                read_clk_out = ~read_clk_out;
                read_data_out = ~read_data_out;
                idle = 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the floppy serdes decoder
`default_nettype none

module testbench
    import fsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, rd_in = 1'b0, wr_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0] data_in = 8'h00, data_out, wq;
    logic sector_in = 1'b0, index_in = 1'b0;
    logic [4:0] drive_lines_in = 5'h15;
    logic data_oe_out, ready_out, head_load_out, beyond_track_out, irq_out;
    logic step_out, step_dir_out, write_enable_out, phase_locked_osc_out;
    logic write_clk_bit_out, write_data_bit_out, host_addr_bit_fifteen_out;
    logic [3:0] drive_select_out;
    wire shift_clk, read_clk, read_data;
    int error_cnt = 0, check_count = 0, cyc = 0;
    wire [7:0] ctl_lo = {2'b00, beyond_track_out, head_load_out,
        drive_select_out};
    wire [7:0] ctl_hi = {host_addr_bit_fifteen_out, irq_out, 2'b00,
        phase_locked_osc_out, write_enable_out, step_dir_out, step_out};
    wire [7:0] misc = {4'h0, ready_out, data_oe_out, write_clk_bit_out,
        write_data_bit_out};

    always #20 sys_clk_in = ~sys_clk_in;

    fsd_top u_fsd_top (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .addr_in(addr_in), .data_in(data_in), .rd_in(rd_in), .wr_in(wr_in),
        .data_out(data_out), .data_oe_out(data_oe_out),
        .ready_out(ready_out), .shift_clk_in(shift_clk),
        .read_clk_in(read_clk), .read_data_in(read_data),
        .sector_in(sector_in), .index_in(index_in),
        .drive_lines_in(drive_lines_in),
        .drive_select_out(drive_select_out), .head_load_out(head_load_out),
        .beyond_track_out(beyond_track_out), .step_out(step_out),
        .step_dir_out(step_dir_out), .write_enable_out(write_enable_out),
        .phase_locked_osc_out(phase_locked_osc_out),
        .write_clk_bit_out(write_clk_bit_out),
        .write_data_bit_out(write_data_bit_out),
        .host_addr_bit_fifteen_out(host_addr_bit_fifteen_out),
        .irq_out(irq_out));
    fsd_drv u_fsd_drv (.shift_clk_out(shift_clk), .read_clk_out(read_clk),
        .read_data_out(read_data), .wclk_in(write_clk_bit_out),
        .wdat_in(write_data_bit_out));
    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    // Strobe and address held until ready is sampled high
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        addr_in <= a;
        data_in <= d;
        rd_in <= ~w;
        wr_in <= w;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (ready_out !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            error_cnt++;
            results();
        end
        q = data_out;
        rd_in <= 1'b0;
        wr_in <= 1'b0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp,
                       input string what);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_control;
        chk("reset low", 8'h00, ctl_lo);
        chk("reset high", 8'h00, ctl_hi);
        acc(1'b1, REG_DRIVE_CONTROL_LOW, 8'h3A, wq);
        chk("control low", 8'h3A, ctl_lo);
        acc(1'b1, REG_DRIVE_CONTROL_HIGH, 8'h4B, wq);
        chk("control high", 8'h4B, ctl_hi);
        index_in <= 1'b1;
        sector_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        index_in <= 1'b0;
        rdc(REG_DRIVE_STATUS, 8'h75, "status");
        acc(1'b1, REG_DRIVE_CONTROL_HIGH, 8'h80, wq);
        chk("host bit", 8'h80, ctl_hi);
        rdc(REG_DRIVE_STATUS, 8'h35, "index cleared");
        acc(1'b1, REG_DRIVE_STATUS, 8'hFF, wq);
        chk("noop write high", 8'h80, ctl_hi);
        chk("noop write low", 8'h3A, ctl_lo);
        acc(1'b0, 16'hC004, 8'h00, wq);
        chk("outside page", 8'h08, misc);
        rdc(REG_WRITE_DATA_LOAD, UNMAPPED_READ, "reserved");
        $display("control test done");
    endtask

    task automatic t_receive;
        logic [7:0] rx [6] = '{8'hA5, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        u_fsd_drv.send(8'hFF, 8'h00);
        u_fsd_drv.send(CLK_PAT_3, 8'hFB);
        foreach (rx[i]) u_fsd_drv.send(8'hFF, rx[i]);
        rdc(REG_SYNC_DATA_READ, 8'hFB, "sync data");
        rdc(REG_SYNC_CLOCK_READ, CLK_PAT_3, "sync clock");
        wait (u_fsd_drv.idle);
        repeat (12) @(posedge sys_clk_in);
        rdc(REG_DRIVE_STATUS, 8'hB5, "overrun");
        rdc(REG_CLOCK_BYTE_READ, 8'hFF, "clock byte");
        for (int i = 0; i < RX_FIFO_DEPTH; i++)
            rdc(REG_DATA_BYTE_READ, rx[i], "data byte");
        u_fsd_drv.send(8'hFF, 8'h96);
        rdc(REG_DATA_BYTE_READ, 8'h96, "waited byte");
        $display("receive test done");
    endtask

    task automatic t_write;
        logic [31:0] ec = {CLK_PAT_0, CLK_PAT_2, CLK_PAT_1, CLK_PAT_3};
        logic [31:0] ed = {FILL_DATA, 8'h5A, 16'h0000};
        logic hit, ok;
        hit = 1'b0;
        acc(1'b1, REG_DRIVE_CONTROL_HIGH, 8'h04, wq);
        chk("write enable", 8'h04, ctl_hi);
        acc(1'b1, 16'h4017, 8'h5A, wq);
        u_fsd_drv.wc.delete();
        u_fsd_drv.wd.delete();
        repeat (6) u_fsd_drv.send(8'hFF, 8'h00);
        acc(1'b1, 16'h4009, 8'h00, wq);
        acc(1'b1, 16'h4019, 8'h00, wq);
        wait (u_fsd_drv.idle);
        for (int i = 0; i <= 16; i++) begin
            ok = 1'b1;
            for (int b = 0; b < 32; b++)
                if (u_fsd_drv.wc[i + b] !== ec[31 - b] ||
                    u_fsd_drv.wd[i + b] !== ed[31 - b])
                    ok = 1'b0;
            hit = hit | ok;
        end
        chk("write stream", 8'h01, {7'h00, hit});
        $display("write test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        t_control();
        t_receive();
        t_write();
        results();
    end
endmodule

`default_nettype wire
